// ===== pkg/hbseq_pkg.sv
package hbseq_pkg;
	// register indices, one per setting word
	localparam logic [15:0] REG_BRAKE_POWER_OFF_DELAY = 16'h2506;
	localparam logic [15:0] REG_OUTPUT_PIN_ALLOCATION = 16'h250F;
	localparam logic [15:0] REG_BRAKE_WAIT_TIME = 16'h2508;
	localparam logic [15:0] REG_BRAKE_SPEED_LEVEL = 16'h2507;
	// reset values
	localparam logic [15:0] BRAKE_POWER_OFF_DELAY_RST = 16'h0000;
	localparam logic [15:0] OUTPUT_PIN_ALLOCATION_RST = 16'h0100;
	localparam logic [15:0] BRAKE_WAIT_TIME_RST = 16'h0032;
	localparam logic [15:0] BRAKE_SPEED_LEVEL_RST = 16'h0064;
	// field layout: brake allocation digit of the allocation register
	localparam int ALLOC_LSB = 8;
	localparam int ALLOC_W = 4;
	localparam logic [3:0] ALLOC_UNUSED = 4'h0;
	localparam logic [3:0] ALLOC_MAX = 4'h3;
	// setting limits
	localparam logic [15:0] DELAY_MAX = 16'h0032;
	localparam logic [15:0] WAIT_MIN = 16'h000A;
	localparam logic [15:0] WAIT_MAX = 16'h0064;
	// timing
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	typedef enum logic [2:0] {
		HBSEQ_OFF,
		HBSEQ_ON,
		HBSEQ_STOP_DELAY,
		HBSEQ_RUN_WAIT
	} hbseq_state_e;
endpackage

// ===== pkg/hbseq_tick_if.sv
`timescale 1ns/1ns
interface hbseq_tick_if;
	logic tick;
	logic load;
	logic clear;
	logic [15:0] load_val;
	logic done;
	modport src(output tick);
	modport sink(input tick);
	modport ctl(output load, output clear, output load_val, input done);
	modport tmr(input tick, input load, input clear, input load_val, output done);
endinterface

// ===== hw/hbseq_tick.sv
`timescale 1ns/1ns
module hbseq_tick #(
	parameter int CYCLES = hbseq_pkg::TICK_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	hbseq_tick_if.src tk
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] cnt_r;
	logic tick_r;
	initial begin
		if (CYCLES < 2)
			$error("tick period too short");
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else if (cnt_r == CW'(CYCLES - 1)) begin
			cnt_r <= '0;
			tick_r <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick_r <= 1'b0;
		end
	end
	assign tk.tick = tick_r;
endmodule

// ===== hw/hbseq_timer.sv
`timescale 1ns/1ns
module hbseq_timer (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	hbseq_tick_if.tmr t
);
	logic [15:0] cnt_r;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || t.clear)
			cnt_r <= '0;
		else if (t.load)
			cnt_r <= t.load_val;
		else if (t.tick && cnt_r != 16'h0000)
			cnt_r <= cnt_r - 1'b1;
	end
	assign t.done = (cnt_r == 16'h0000) && !t.load;
endmodule

// ===== hw/hbseq_top.sv
`timescale 1ns/1ns
module hbseq_top #(
	parameter int TICK_CYCLES = hbseq_pkg::TICK_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic servo_on_command_i,
	input wire logic alarm_i,
	input wire logic overtravel_i,
	input wire logic motor_stopped_i,
	input wire logic [15:0] motor_speed_i,
	input wire logic [2:0] other_out_i,
	input wire logic reg_wr_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	output logic motor_power_o,
	output logic brake_release_output_o,
	output logic [2:0] out_pin_o
);
	hbseq_tick_if tif();
	logic [15:0] delay_r;
	logic [15:0] alloc_r;
	logic [15:0] wait_r;
	logic [15:0] level_r;
	logic [3:0] alloc_act_r;
	logic [2:0] sync_a_r;
	logic [2:0] sync_b_r;
	logic [2:0] other_a_r;
	logic [2:0] other_b_r;
	logic servo_on;
	logic alarm;
	logic overtravel;
	logic tmr_load;
	logic tmr_clear;
	logic [15:0] tmr_val;
	hbseq_pkg::hbseq_state_e state_r;
	hbseq_pkg::hbseq_state_e state_nxt;
	logic release_nxt;
	logic power_nxt;
	logic [2:0] pin_nxt;
	hbseq_tick #(.CYCLES(TICK_CYCLES)) u_tick (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.tk(tif.src)
	);
	hbseq_timer u_timer (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.t(tif.tmr)
	);
	assign tif.load = tmr_load;
	assign tif.clear = tmr_clear;
	assign tif.load_val = tmr_val;
	// pins from the drive front end pass two flops
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sync_a_r <= 3'h0;
			sync_b_r <= 3'h0;
			other_a_r <= 3'h0;
			other_b_r <= 3'h0;
		end else begin
			sync_a_r <= {overtravel_i, alarm_i, servo_on_command_i};
			sync_b_r <= sync_a_r;
			other_a_r <= other_out_i;
			other_b_r <= other_a_r;
		end
	end
	assign servo_on = sync_b_r[0];
	assign alarm = sync_b_r[1];
	assign overtravel = sync_b_r[2];
	// register writes; out-of-range delay and wait time values are clamped, others stored as written
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			delay_r <= hbseq_pkg::BRAKE_POWER_OFF_DELAY_RST;
			alloc_r <= hbseq_pkg::OUTPUT_PIN_ALLOCATION_RST;
			wait_r <= hbseq_pkg::BRAKE_WAIT_TIME_RST;
			level_r <= hbseq_pkg::BRAKE_SPEED_LEVEL_RST;
		end else if (reg_wr_i) begin
			case (reg_addr_i)
				hbseq_pkg::REG_BRAKE_POWER_OFF_DELAY: begin
					delay_r <= (reg_wdata_i > hbseq_pkg::DELAY_MAX) ?
						hbseq_pkg::DELAY_MAX : reg_wdata_i;
				end
				hbseq_pkg::REG_OUTPUT_PIN_ALLOCATION: begin
					alloc_r <= reg_wdata_i;
				end
				hbseq_pkg::REG_BRAKE_WAIT_TIME: begin
					if (reg_wdata_i < hbseq_pkg::WAIT_MIN)
						wait_r <= hbseq_pkg::WAIT_MIN;
					else if (reg_wdata_i > hbseq_pkg::WAIT_MAX)
						wait_r <= hbseq_pkg::WAIT_MAX;
					else
						wait_r <= reg_wdata_i;
				end
				hbseq_pkg::REG_BRAKE_SPEED_LEVEL: begin
					level_r <= reg_wdata_i;
				end
				default: begin
				end
			endcase
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			alloc_act_r <= hbseq_pkg::OUTPUT_PIN_ALLOCATION_RST[hbseq_pkg::ALLOC_LSB +:
				hbseq_pkg::ALLOC_W];
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 16'h0000;
		end else begin
			case (reg_addr_i)
				hbseq_pkg::REG_BRAKE_POWER_OFF_DELAY: reg_rdata_o <= delay_r;
				hbseq_pkg::REG_OUTPUT_PIN_ALLOCATION: reg_rdata_o <= alloc_r;
				hbseq_pkg::REG_BRAKE_WAIT_TIME: reg_rdata_o <= wait_r;
				hbseq_pkg::REG_BRAKE_SPEED_LEVEL: reg_rdata_o <= level_r;
				default: reg_rdata_o <= 16'h0000;
			endcase
		end
	end
	always_comb begin
		state_nxt = state_r;
		tmr_load = 1'b0;
		tmr_val = delay_r;
		tmr_clear = 1'b0;
		case (state_r)
			hbseq_pkg::HBSEQ_OFF: begin
				if (servo_on && !alarm)
					state_nxt = hbseq_pkg::HBSEQ_ON;
			end
			hbseq_pkg::HBSEQ_ON: begin
				if (alarm) begin
					// alarm skips delay
					// brake drops on alarm anyway, so no run-wait here
					tmr_clear = 1'b1;
					state_nxt = hbseq_pkg::HBSEQ_OFF;
				end else if (!servo_on) begin
					tmr_load = 1'b1;
					tmr_val = motor_stopped_i ? delay_r : wait_r;
					state_nxt = motor_stopped_i ? hbseq_pkg::HBSEQ_STOP_DELAY :
						hbseq_pkg::HBSEQ_RUN_WAIT;
				end
			end
			hbseq_pkg::HBSEQ_STOP_DELAY: begin
				if (alarm) begin
					tmr_clear = 1'b1;
					state_nxt = hbseq_pkg::HBSEQ_OFF;
				end else if (tif.done)
					state_nxt = hbseq_pkg::HBSEQ_OFF;
			end
			hbseq_pkg::HBSEQ_RUN_WAIT: begin
				// speed level or wait time
				// alarm ends it too, else the brake would lift again
				if (alarm || motor_speed_i < level_r || tif.done)
					state_nxt = hbseq_pkg::HBSEQ_OFF;
			end
			default: state_nxt = hbseq_pkg::HBSEQ_OFF;
		endcase
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			state_r <= hbseq_pkg::HBSEQ_OFF;
		else
			state_r <= state_nxt;
	end
	always_comb begin
		// release while on with servo on, or in run wait, and not alarmed
		release_nxt = ((state_nxt == hbseq_pkg::HBSEQ_ON) && servo_on ||
			state_nxt == hbseq_pkg::HBSEQ_RUN_WAIT) && !alarm;
		// overtravel never applies brake by itself
		if (overtravel && state_nxt == hbseq_pkg::HBSEQ_ON && !alarm)
			release_nxt = 1'b1;
		// at standstill power outlives output by the delay; in run wait power is off while output stays on
		power_nxt = (state_nxt == hbseq_pkg::HBSEQ_ON) ||
			(state_nxt == hbseq_pkg::HBSEQ_STOP_DELAY);
		if (alarm)
			power_nxt = 1'b0;
	end
	// or with other functions on the pin
	always_comb begin
		pin_nxt = other_b_r;
		if (alloc_act_r != hbseq_pkg::ALLOC_UNUSED && alloc_act_r <= hbseq_pkg::ALLOC_MAX)
			pin_nxt[alloc_act_r[1:0] - 2'h1] = other_b_r[alloc_act_r[1:0] - 2'h1] | release_nxt;
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			brake_release_output_o <= 1'b0;
			motor_power_o <= 1'b0;
			out_pin_o <= 3'h0;
		end else begin
			brake_release_output_o <= release_nxt;
			motor_power_o <= power_nxt;
			out_pin_o <= pin_nxt;
		end
	end
	// servo off seen while on and at standstill
	sequence seq_off_at_rest;
		state_r == hbseq_pkg::HBSEQ_ON && !servo_on && !alarm && motor_stopped_i;
	endsequence
	AST_ALARM_DROPS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		alarm |=> !brake_release_output_o && !motor_power_o)
		else $error("alarm did not drop outputs");
	AST_ALARM_POWER: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(alarm) |=> !motor_power_o)
		else $error("power not cut on alarm");
	AST_OFF_DROPS: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		seq_off_at_rest |=> !brake_release_output_o && motor_power_o)
		else $error("output held after servo off");
	AST_DELAY_POWER: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_r == hbseq_pkg::HBSEQ_STOP_DELAY && !alarm && !tif.done)
		|=> motor_power_o)
		else $error("power removed before delay");
	AST_OT_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(overtravel && servo_on && !alarm && state_r == hbseq_pkg::HBSEQ_ON)
		|=> brake_release_output_o)
		else $error("brake applied on overtravel");
	AST_PWR_ORDER: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		brake_release_output_o && state_r != hbseq_pkg::HBSEQ_RUN_WAIT |-> motor_power_o)
		else $error("released without power");
	AST_CLEAR_TMR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_r == hbseq_pkg::HBSEQ_STOP_DELAY && alarm) |=> tif.done)
		else $error("timer not cleared");
	AST_WAIT_END: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_r == hbseq_pkg::HBSEQ_RUN_WAIT && motor_speed_i < level_r)
		|=> state_r == hbseq_pkg::HBSEQ_OFF)
		else $error("run wait not ended");
	AST_WAIT_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_r == hbseq_pkg::HBSEQ_RUN_WAIT && !alarm && motor_speed_i >= level_r &&
		!tif.done) |=> brake_release_output_o)
		else $error("brake dropped while coasting");
	AST_PIN_OR: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		brake_release_output_o && alloc_act_r == 4'h1 |-> out_pin_o[0])
		else $error("pin not ored");
endmodule

// ===== testbench/hbseq_brake_model.sv
`timescale 1ns/1ns
module hbseq_brake_model #(
	parameter int REL_CYC = 6,
	parameter int OP_CYC = 8
) (
	input wire logic sys_clk_i,
	input wire logic release_i,
	output logic released_o
);
	int cnt = 0;
	initial released_o = 1'b0;
	always @(posedge sys_clk_i) begin
		if (release_i == released_o) begin
			cnt <= 0;
		end else if (cnt >= (release_i ? REL_CYC : OP_CYC)) begin
			released_o <= release_i;
			cnt <= 0;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// ===== testbench/holding_brake_sequencer_tb.sv
`timescale 1ns/1ns
module holding_brake_sequencer_tb;
	localparam int TK = 10;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic servo_on_command_i = 1'b0;
	logic alarm_i = 1'b0;
	logic overtravel_i = 1'b0;
	logic motor_stopped_i = 1'b1;
	logic [15:0] motor_speed_i = 16'h0000;
	logic [2:0] other_out_i = 3'h0;
	logic reg_wr_i = 1'b0;
	logic [15:0] reg_addr_i = 16'h0000;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic [15:0] reg_rdata_o;
	logic motor_power_o;
	logic brake_release_output_o;
	logic [2:0] out_pin_o;
	logic released;
	int fail_count = 0;
	int samples_checked = 0;
	int c;
	always #50 sys_clk_i = ~sys_clk_i;
	hbseq_top #(.TICK_CYCLES(TK)) dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.servo_on_command_i(servo_on_command_i), .alarm_i(alarm_i),
		.overtravel_i(overtravel_i), .motor_stopped_i(motor_stopped_i),
		.motor_speed_i(motor_speed_i), .other_out_i(other_out_i), .reg_wr_i(reg_wr_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
		.motor_power_o(motor_power_o), .brake_release_output_o(brake_release_output_o),
		.out_pin_o(out_pin_o));
	hbseq_brake_model brk_u (.sys_clk_i(sys_clk_i), .release_i(brake_release_output_o),
		.released_o(released));
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	task automatic close_out();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		tick(1);
		reg_wr_i = 1'b0;
	endtask
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
		reg_addr_i = a;
		tick(2);
		chk(reg_rdata_o, e, "readback");
	endtask
	// sel 1 waits on motor power, sel 0 on the brake output
	task automatic wait_for(input bit sel, input logic v, input int n, output int k);
		for (k = 0; k < n; k++) begin
			if ((sel ? motor_power_o : brake_release_output_o) === v) break;
			tick(1);
		end
		if (k == n) begin
			fail_count++;
			$display("unexpected at %0t: wait ran out", $time);
			close_out();
		end
	endtask
	task automatic t_reset();
		chk({13'h0, motor_power_o, brake_release_output_o, out_pin_o[0]}, 16'h0, "idle");
		rd_chk(hbseq_pkg::REG_BRAKE_POWER_OFF_DELAY, 16'h0000);
		rd_chk(hbseq_pkg::REG_OUTPUT_PIN_ALLOCATION, 16'h0100);
		rd_chk(16'h1234, 16'h0000);
		$display("test reset done");
	endtask
	task automatic servo_on();
		servo_on_command_i = 1'b1;
		wait_for(0, 1'b1, 8, c);
		tick(1);
		chk(16'(motor_power_o), 16'h1, "power on");
	endtask
	task automatic t_on();
		servo_on();
		chk(16'(out_pin_o), 16'h1, "pin pair 1");
		// host holds motion for a scaled 50 ms plus release lag
		tick(5 * TK + 8);
		chk(16'(released), 16'h1, "brake free");
		$display("test servo_on done");
	endtask
	task automatic t_stop(input int d);
		wr(hbseq_pkg::REG_BRAKE_POWER_OFF_DELAY, 16'(d));
		rd_chk(hbseq_pkg::REG_BRAKE_POWER_OFF_DELAY, 16'(d));
		servo_on();
		servo_on_command_i = 1'b0;
		wait_for(0, 1'b0, 5, c);
		wait_for(1, 1'b0, d * TK + 3 * TK, c);
		chk(16'(c + TK >= d * TK && c <= d * TK + 2 * TK), 16'h1, "off delay");
		$display("test stop delay %0d done", d);
	endtask
	task automatic t_alarm();
		servo_on();
		alarm_i = 1'b1;
		wait_for(1, 1'b0, 6, c);
		chk(16'(brake_release_output_o), 16'h0, "brake on alarm");
		servo_on_command_i = 1'b0;
		alarm_i = 1'b0;
		tick(4);
		$display("test alarm done");
	endtask
	task automatic t_ot_or();
		other_out_i = 3'b110;
		tick(5);
		chk(16'(out_pin_o), 16'h6, "or off");
		servo_on();
		overtravel_i = 1'b1;
		wr(hbseq_pkg::REG_OUTPUT_PIN_ALLOCATION, 16'h0200);
		tick(20);
		chk(16'(brake_release_output_o), 16'h1, "overtravel");
		chk(16'(out_pin_o), 16'h7, "or on");
		rd_chk(hbseq_pkg::REG_OUTPUT_PIN_ALLOCATION, 16'h0200);
		// brake pin kept dedicated from here on
		other_out_i = 3'b000;
		overtravel_i = 1'b0;
		servo_on_command_i = 1'b0;
		// delay is still 50 ticks here
		wait_for(1, 1'b0, 60 * TK, c);
		$display("test overtravel done");
	endtask
	task automatic t_moving();
		wr(hbseq_pkg::REG_BRAKE_POWER_OFF_DELAY, 16'h0000);
		servo_on();
		motor_stopped_i = 1'b0;
		motor_speed_i = 16'h01F4;
		tick(3);
		servo_on_command_i = 1'b0;
		wait_for(1, 1'b0, 6, c);
		tick(10);
		chk(16'(brake_release_output_o), 16'h1, "still moving");
		motor_speed_i = 16'h0032;
		wait_for(0, 1'b0, 8, c);
		motor_stopped_i = 1'b1;
		motor_speed_i = 16'h0000;
		// wait time below range is clamped to 10 ticks
		wr(hbseq_pkg::REG_BRAKE_WAIT_TIME, 16'h0005);
		rd_chk(hbseq_pkg::REG_BRAKE_WAIT_TIME, 16'h000A);
		servo_on();
		motor_stopped_i = 1'b0;
		motor_speed_i = 16'h01F4;
		servo_on_command_i = 1'b0;
		wait_for(0, 1'b0, 12 * TK, c);
		chk(16'(c >= 9 * TK && c <= 11 * TK), 16'h1, "wait time");
		motor_stopped_i = 1'b1;
		motor_speed_i = 16'h0000;
		$display("test moving done");
	endtask
	task automatic t_restart();
		servo_on();
		rst_i = 1'b1;
		tick(2);
		chk({13'h0, motor_power_o, brake_release_output_o, out_pin_o[0]}, 16'h0, "restart");
		rst_i = 1'b0;
		servo_on_command_i = 1'b0;
		tick(1);
		rd_chk(hbseq_pkg::REG_OUTPUT_PIN_ALLOCATION, 16'h0100);
		servo_on();
		chk(16'(out_pin_o), 16'h1, "pin after restart");
		servo_on_command_i = 1'b0;
		tick(4);
		$display("test restart done");
	endtask
	initial begin
		tick(8);
		rst_i = 1'b0;
		tick(1);
		t_reset();
		t_on();
		servo_on_command_i = 1'b0;
		tick(4);
		t_stop(0);
		t_stop(3);
		t_stop(50);
		t_alarm();
		t_ot_or();
		t_moving();
		t_restart();
		close_out();
	end
endmodule
